// *** logic/stereo_dac_serial_audio_rx.sv ***
// Top of the slave serial audio receiver with ratio detect and soft mute.
// Assumes ref_clk is the master clock; link pins are asynchronous to it.
`timescale 1ns/1ps
module stereo_dac_serial_audio_rx (
   input wire logic ref_clk, // Master clock, 10 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic supply_reset_bar, // Supply monitor, low holds reset
   input wire logic bit_clk, // Serial bit clock from source
   input wire logic frame_clk, // Left/right frame clock from source
   input wire logic serial_sample_in, // Serial audio data
   input wire logic framing_select_pin, // Format pin level when driven
   input wire logic framing_select_hiz, // High when format pin undriven
   input wire logic mute_n, // Mute request, active low
   output logic [audio_rx_pkg::SAMPLE_W-1:0] left_out, // Scaled left sample
   output logic [audio_rx_pkg::SAMPLE_W-1:0] right_out, // Scaled right sample
   output logic sample_valid, // Pulse with each output pair
   output logic muted, // High while mute is requested or bit clock is stopped; three cycles after mute_n, one after the stop flag
   output logic bit_clk_stopped, // High while bit clock is idle
   output logic ratio_locked, // High when ratio matches a table entry
   output logic [2:0] ratio_index // Index of detected ratio
);
   import audio_rx_pkg::*;

   localparam int unsigned NSYNC = 7; // Synchronised inputs

   logic [NSYNC-1:0] raw_in; // Pins before sync
   logic [NSYNC-1:0] sync1_q; // First sync stage
   logic [NSYNC-1:0] sync2_q; // Second sync stage
   logic bclk_prev_q; // Bit clock level last cycle
   logic fclk_prev_q; // Frame clock level last cycle
   logic por_ok; // Supply reset released
   logic clear; // Hold logic at defaults
   logic bit_rise; // Bit clock rising edge
   logic frame_rise; // Frame clock rising edge
   logic [STOP_CNT_W-1:0] stop_cnt_q; // Cycles since last bit edge
   logic stopped_q; // Bit clock judged stopped
   logic [FRAME_CNT_W-1:0] frame_cnt_q; // Master cycles this frame
   logic [NUM_RATIOS-1:0] ratio_hit; // Per-entry match
   logic locked_q; // Ratio match held
   logic [2:0] ratio_q; // Matched entry
   logic [2:0] ratio_enc; // Encoded match
   mute_state_t mute_state_q; // Soft mute state
   logic [GAIN_W-1:0] gain_q; // Gain, GAIN_FULL is unity
   logic [SAMPLE_W-1:0] left_q; // Output left
   logic [SAMPLE_W-1:0] right_q; // Output right
   logic valid_q; // Output pulse
   logic want_mute; // Mute request from pin or monitor
   logic muted_q; // Registered mute flag
   logic signed [SAMPLE_W+GAIN_W:0] left_prod; // Left word times gain
   logic signed [SAMPLE_W+GAIN_W:0] right_prod; // Right word times gain

   rx_link_if link ();

   // Two-flop synchronisers for every pin
   assign raw_in = {supply_reset_bar, bit_clk, frame_clk, serial_sample_in,
                    framing_select_pin, framing_select_hiz, mute_n};
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Supply reset gates everything downstream
   assign por_ok = sync2_q[6];
   assign clear = !por_ok;

   // Edge finders on the synchronised clocks
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bclk_prev_q <= 1'b0;
         fclk_prev_q <= 1'b0;
      end else begin
         // Track the pins under supply reset too, so release shows no false edge
         bclk_prev_q <= sync2_q[5];
         fclk_prev_q <= sync2_q[4];
      end
   end
   assign bit_rise = sync2_q[5] && !bclk_prev_q && por_ok;
   assign frame_rise = sync2_q[4] && !fclk_prev_q && por_ok;

   // Link hand-off to the word assembler
   assign link.bit_rise = bit_rise;
   assign link.frame_lvl = sync2_q[4];
   assign link.data_bit = sync2_q[3];
   // Undriven pin wins over its level
   assign link.fmt = sync2_q[1] ? FMT_RJ : (sync2_q[2] ? FMT_I2S : FMT_LJ);

   frame_word_assembler u_asm (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clear(clear),
      .link(link)
   );

   // Bit clock monitor
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stop_cnt_q <= '0;
         stopped_q <= 1'b1;
      end else if (clear) begin
         stop_cnt_q <= '0;
         stopped_q <= 1'b1;
      end else if (bit_rise) begin
         stop_cnt_q <= '0;
         stopped_q <= 1'b0;
      end else if (stop_cnt_q == STOP_CNT_W'(BCLK_STOP_CYC - 1)) begin
         stopped_q <= 1'b1;
      end else begin
         stop_cnt_q <= stop_cnt_q + 8'h01;
      end
   end

   // Compare frame length against each supported ratio
   generate
      for (genvar i = 0; i < NUM_RATIOS; i++) begin : g_ratio
         assign ratio_hit[i] = (frame_cnt_q + RATIO_TOL >= RATIO_TABLE[i]) &&
                               (frame_cnt_q <= RATIO_TABLE[i] + RATIO_TOL);
      end
   endgenerate

   // Encode lowest matching entry
   always_comb begin
      ratio_enc = 3'h0;
      for (int j = NUM_RATIOS - 1; j >= 0; j--) begin
         if (ratio_hit[j])
            ratio_enc = 3'(j);
      end
   end

   // Master cycles per frame, judged at each frame rising edge
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         frame_cnt_q <= '0;
         locked_q <= 1'b0;
         ratio_q <= 3'h0;
      end else if (clear) begin
         frame_cnt_q <= '0;
         locked_q <= 1'b0;
         ratio_q <= 3'h0;
      end else if (frame_rise) begin
         frame_cnt_q <= 12'h001;
         locked_q <= |ratio_hit;
         ratio_q <= ratio_enc;
      end else if (frame_cnt_q != 12'hFFF) begin
         frame_cnt_q <= frame_cnt_q + 12'h001;
      end
   end

   // Soft mute: ramp down per sample pair, restore in one step
   assign want_mute = !sync2_q[0] || stopped_q;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         mute_state_q <= MUTE_SILENT;
         gain_q <= '0;
      end else if (clear) begin
         mute_state_q <= MUTE_SILENT;
         gain_q <= '0;
      end else begin
         case (mute_state_q)
            MUTE_PLAY: begin
               if (want_mute)
                  mute_state_q <= MUTE_RAMP;
            end
            MUTE_RAMP: begin
               if (!want_mute) begin
                  gain_q <= GAIN_FULL;
                  mute_state_q <= MUTE_PLAY;
               end else if (gain_q == '0) begin
                  mute_state_q <= MUTE_SILENT;
               end else if (link.pair_valid || stopped_q) begin
                  // A stopped clock brings no samples, so step on time
                  gain_q <= gain_q - 10'h001;
               end
            end
            MUTE_SILENT: begin
               if (!want_mute) begin
                  gain_q <= GAIN_FULL;
                  mute_state_q <= MUTE_PLAY;
               end
            end
            default: begin
               mute_state_q <= MUTE_SILENT;
               gain_q <= '0;
            end
         endcase
      end
   end

   // Registered mute flag; every legal state leaves play exactly when mute is wanted
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         muted_q <= 1'b1;
      end else if (clear) begin
         muted_q <= 1'b1;
      end else begin
         muted_q <= want_mute;
      end
   end

   // Full-width products so scaling never overflows the word size
   assign left_prod = $signed(link.left_word) * $signed({1'b0, gain_q});
   assign right_prod = $signed(link.right_word) * $signed({1'b0, gain_q});

   // Scale each pair by the current gain
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= '0;
         right_q <= '0;
         valid_q <= 1'b0;
      end else if (clear) begin
         left_q <= '0;
         right_q <= '0;
         valid_q <= 1'b0;
      end else begin
         valid_q <= link.pair_valid;
         if (link.pair_valid) begin
            // Quotient fits the word again, so the cut keeps every value bit
            left_q <= SAMPLE_W'(left_prod / $signed({1'b0, GAIN_FULL}));
            right_q <= SAMPLE_W'(right_prod / $signed({1'b0, GAIN_FULL}));
         end
      end
   end

   assign left_out = left_q;
   assign right_out = right_q;
   assign sample_valid = valid_q;
   assign muted = muted_q;
   assign bit_clk_stopped = stopped_q;
   assign ratio_locked = locked_q;
   assign ratio_index = ratio_q;
endmodule

// *** logic/audio_rx_pkg.sv ***
// Constants, types and timing counts shared by the serial audio receiver.
// Assumes a 10 MHz ref_clk that also serves as the master clock.
// How it works
// - Sample frame level and data on bit-clock rise.
// - Frame level picks channel, transitions align words.
// - All formats arrive most significant bit first.
// - Right-justified LSB is last edge before transition.
// - Right-justified surplus leading edges are ignored.
// - Left-justified MSB on first edge after transition.
// - Left-justified surplus trailing edges are ignored.
// - I2S MSB on second edge after transition.
// - I2S surplus edges between words are ignored.
// - Stopped bit clock mutes the output.
// - Detect master-to-frame ratio within 32 cycles.
// - Accept ratios 128fs to 1152fs.
// - Supply reset holds logic at defaults.
// - Inputs ignored while supply reset active.
// - Defaults on release, then inputs accepted.
// - Three-level pin picks LJ, I2S or RJ.
// - Mute ramps over 800 samples, unmute steps.
package audio_rx_pkg;

   // Word and ratio detector sizes
   localparam int unsigned SAMPLE_W = 24;
   localparam int unsigned BITCNT_W = 6;
   localparam int unsigned FRAME_CNT_W = 12;
   localparam int unsigned NUM_RATIOS = 7;
   localparam logic [FRAME_CNT_W-1:0] RATIO_TOL = 12'h020;

   // Supported master-to-frame ratios, in master clock cycles per frame
   localparam logic [FRAME_CNT_W-1:0] RATIO_TABLE [NUM_RATIOS] = '{
      12'h080, 12'h0C0, 12'h100, 12'h180, 12'h200, 12'h300, 12'h480};

   // Slot positions within a channel slot
   localparam logic [BITCNT_W-1:0] LJ_FIRST_EDGE = 6'h01;
   localparam logic [BITCNT_W-1:0] I2S_FIRST_EDGE = 6'h02;

   // Soft mute ramp length in samples
   localparam int unsigned GAIN_W = 10;
   localparam logic [GAIN_W-1:0] GAIN_FULL = 10'h320;

   // Bit clock stop detection
   localparam int unsigned REF_CLK_PERIOD_NS = 100;
   localparam int unsigned BCLK_STOP_NS = 20000;
   localparam int unsigned BCLK_STOP_CYC =
      (BCLK_STOP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
   localparam int unsigned STOP_CNT_W = 8;

   // Framing formats chosen by the three-level pin
   typedef enum logic [1:0] {
      FMT_LJ = 2'b00,
      FMT_I2S = 2'b01,
      FMT_RJ = 2'b10
   } fmt_t;

   // Soft mute controller states
   typedef enum logic [1:0] {
      MUTE_PLAY = 2'b00,
      MUTE_RAMP = 2'b01,
      MUTE_SILENT = 2'b10
   } mute_state_t;

endpackage

// *** logic/rx_link_if.sv ***
// Carries sampled serial-link events from the top to the word assembler.
// Assumes all signals are on ref_clk.
`timescale 1ns/1ps
interface rx_link_if;
   import audio_rx_pkg::*;
   logic bit_rise; // One-cycle pulse per bit-clock rising edge
   logic frame_lvl; // Frame clock level at that edge
   logic data_bit; // Serial data at that edge
   fmt_t fmt; // Active framing format
   logic [SAMPLE_W-1:0] left_word; // Assembled left sample
   logic [SAMPLE_W-1:0] right_word; // Assembled right sample
   logic pair_valid; // Pulse when a stereo pair is complete

   modport top (output bit_rise, frame_lvl, data_bit, fmt,
                input left_word, right_word, pair_valid);
   modport asm (input bit_rise, frame_lvl, data_bit, fmt,
                output left_word, right_word, pair_valid);
endinterface

// *** logic/frame_word_assembler.sv ***
// Turns bit-clock events into left and right sample words.
// Assumes one bit_rise pulse per bit clock edge and a synchronous clear.
`timescale 1ns/1ps
module frame_word_assembler (
   input wire logic ref_clk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic clear, // Held high while supply reset is active
   rx_link_if.asm link // Link events and assembled words
);
   import audio_rx_pkg::*;

   logic prev_lvl_q; // Frame level at previous edge
   logic [BITCNT_W-1:0] edge_cnt_q; // Edges since last transition
   logic [SAMPLE_W-1:0] word_q; // Word under assembly (LJ/I2S)
   logic [SAMPLE_W-1:0] shift_q; // Last bits seen (RJ)
   logic [SAMPLE_W-1:0] left_q; // Held left word
   logic [SAMPLE_W-1:0] right_q; // Held right word
   logic pair_q; // Pair complete pulse
   logic trans; // Frame transition at this edge
   logic [BITCNT_W-1:0] pos; // Bit position in the slot
   logic [BITCNT_W-1:0] first; // Edge holding the MSB
   logic [SAMPLE_W-1:0] done_word; // Word finished at a transition

   // Transition and position decode
   always_comb begin
      trans = link.frame_lvl != prev_lvl_q;
      first = (link.fmt == FMT_I2S) ? I2S_FIRST_EDGE : LJ_FIRST_EDGE;
      pos = (trans ? 6'h01 : edge_cnt_q + 6'h01) - first;
      done_word = (link.fmt == FMT_RJ) ? shift_q : word_q;
   end

   // Edge counting and bit capture
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prev_lvl_q <= 1'b0;
         edge_cnt_q <= '0;
         word_q <= '0;
         shift_q <= '0;
      end else if (clear) begin
         prev_lvl_q <= 1'b0;
         edge_cnt_q <= '0;
         word_q <= '0;
         shift_q <= '0;
      end else if (link.bit_rise) begin
         prev_lvl_q <= link.frame_lvl;
         // Saturate so long slots never wrap into a second word
         if (trans)
            edge_cnt_q <= 6'h01;
         else if (edge_cnt_q != 6'h3F)
            edge_cnt_q <= edge_cnt_q + 6'h01;
         // Right-justified keeps the newest bits; older ones fall off
         shift_q <= {shift_q[SAMPLE_W-2:0], link.data_bit};
         if (trans) begin
            // Fresh slot starts zeroed so short words pad low bits
            word_q <= '0;
            if (link.fmt == FMT_LJ)
               word_q[SAMPLE_W-1] <= link.data_bit;
         end else if (link.fmt != FMT_RJ && !pos[BITCNT_W-1] && pos < 6'h18) begin
            // Bits past the 24th, or before the MSB, are dropped
            word_q[SAMPLE_W-1-pos[4:0]] <= link.data_bit;
         end
      end
   end

   // Commit finished slot to its channel on each transition
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= '0;
         right_q <= '0;
         pair_q <= 1'b0;
      end else if (clear) begin
         left_q <= '0;
         right_q <= '0;
         pair_q <= 1'b0;
      end else begin
         pair_q <= 1'b0;
         if (link.bit_rise && trans) begin
            if (!prev_lvl_q) begin
               left_q <= done_word;
            end else begin
               right_q <= done_word;
               pair_q <= 1'b1;
            end
         end
      end
   end

   assign link.left_word = left_q;
   assign link.right_word = right_q;
   assign link.pair_valid = pair_q;
endmodule

// *** verif/audio_src_model.sv ***
// Behavioural serial audio source that drives the link pins.
// Assumes the bench keeps its inputs steady across a frame.
`timescale 1ns/1ps
module audio_src_model (
   input wire logic run, // Stream frames while high
   input wire audio_rx_pkg::fmt_t fmt, // Framing to send
   input wire logic [5:0] slot, // Bit clocks per slot
   input wire logic [23:0] lw, // Left word
   input wire logic [23:0] rw, // Right word
   output logic bclk, // Bit clock
   output logic lrclk, // Frame clock
   output logic sd // Serial data
);
   import audio_rx_pkg::*;
   // Frame generator; clock stands still while idle
   initial begin
      int b;
      bclk = 1'b0;
      lrclk = 1'b0;
      sd = 1'b0;
      #137;
      forever begin
         if (!run) begin
            sd = ~sd; // Idle data keeps moving
            #800;
         end else begin
            for (int s = 0; s < 2; s++) begin
               for (int k = 0; k < int'(slot); k++) begin
                  b = (fmt == FMT_LJ) ? k : (fmt == FMT_I2S) ? k - 1 : k - int'(slot) + 24;
                  lrclk = s[0];
                  sd = (b >= 0 && b < 24) ? (s[0] ? rw[23 - b] : lw[23 - b]) : ~sd;
                  #400 bclk = 1'b1;
                  #400 bclk = 1'b0;
               end
            end
         end
      end
   end
endmodule

// *** verif/audio_rx_props.sv ***
// Port-level checks on the serial audio receiver.
// Assumes one clock domain, ref_clk, reset by resetn.
`timescale 1ns/1ps
module audio_rx_props (
   input wire logic ref_clk, // Master clock
   input wire logic resetn, // Async reset, active low
   input wire logic supply_reset_bar, // Supply monitor
   input wire logic bit_clk, // Bit clock pin
   input wire logic mute_n, // Mute request
   input wire logic [audio_rx_pkg::SAMPLE_W-1:0] left_out, // Left sample
   input wire logic [audio_rx_pkg::SAMPLE_W-1:0] right_out, // Right sample
   input wire logic sample_valid, // Pair strobe
   input wire logic muted, // Mute status
   input wire logic bit_clk_stopped, // Idle flag
   input wire logic ratio_locked, // Ratio match
   input wire logic [2:0] ratio_index // Detected ratio
);
   import audio_rx_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   logic bclk_q; // Last bit clock level
   logic [8:0] idle_q; // Cycles since bit clock moved
   // Saturating idle counter
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         bclk_q <= 1'b0;
         idle_q <= 9'h000;
      end else begin
         bclk_q <= bit_clk;
         idle_q <= (bit_clk != bclk_q) ? 9'h000 : idle_q + {8'h00, idle_q != 9'h1FF};
      end
   end
   property p_pulse;
      sample_valid |=> !sample_valid;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("pair strobe too long");
   property p_clear;
      !supply_reset_bar [*5] |-> muted && bit_clk_stopped && !sample_valid
         && !ratio_locked && left_out == 24'h000000 && right_out == 24'h000000;
   endproperty
   a_clear: assert property (p_clear)
      else $error("supply reset left state");
   property p_stop_mute;
      bit_clk_stopped |=> muted;
   endproperty
   a_stop_mute: assert property (p_stop_mute)
      else $error("stopped but not muted");
   property p_stop_time;
      idle_q > 9'h0DC |-> bit_clk_stopped;
   endproperty
   a_stop_time: assert property (p_stop_time)
      else $error("idle bit clock not flagged");
   property p_edge_seen;
      ($rose(bit_clk) && supply_reset_bar) ##1 supply_reset_bar [*6] |-> !bit_clk_stopped;
   endproperty
   a_edge_seen: assert property (p_edge_seen)
      else $error("bit edge not seen");
   property p_hold;
      !muted && supply_reset_bar ##1 !sample_valid |-> $stable(left_out) && $stable(right_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output moved without strobe");
   property p_mute;
      !mute_n [*4] |-> muted;
   endproperty
   a_mute: assert property (p_mute)
      else $error("mute request ignored");
   property p_ratio;
      ratio_locked |-> ratio_index <= 3'h6;
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("ratio index out of table");
endmodule
bind stereo_dac_serial_audio_rx audio_rx_props props_u (.ref_clk, .resetn, .supply_reset_bar,
   .bit_clk, .mute_n, .left_out, .right_out, .sample_valid, .muted, .bit_clk_stopped,
   .ratio_locked, .ratio_index);

// *** verif/tb_stereo_dac_serial_audio_rx.sv ***
// Self-checking bench for the serial audio receiver.
// Assumes the source model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_stereo_dac_serial_audio_rx;
   import audio_rx_pkg::*;
   logic ref_clk = 1'b0, resetn = 1'b0, supply_reset_bar = 1'b0; // Clock and resets
   logic pin = 1'b0, hiz = 1'b0, mute_n = 1'b1, run = 1'b0; // Controls
   fmt_t fmt = FMT_LJ; // Source framing
   logic [5:0] slot = 6'h20; // Bit clocks per slot
   logic [23:0] lw = 24'h000000, rw = 24'h000000, exp_l, exp_r; // Sent and model words
   wire bclk, lrclk, sd; // Link pins
   logic [23:0] left_out, right_out; // Design outputs
   logic sample_valid, muted, bit_clk_stopped, ratio_locked; // Status
   logic [2:0] ratio_index; // Detected ratio
   int err_total = 0, compares = 0, cyc = 0, skip = 99, seed = 32'h397216e0;
   fmt_t cf[5] = '{FMT_LJ, FMT_I2S, FMT_RJ, FMT_RJ, FMT_I2S}; // Case framings
   logic [5:0] cs[5] = '{6'h20, 6'h20, 6'h20, 6'h18, 6'h18}; // Case slot lengths
   logic [2:0] ci[5] = '{3'h4, 3'h4, 3'h4, 3'h3, 3'h3}; // 512fs and 384fs
   audio_src_model src_u (.run, .fmt, .slot, .lw, .rw, .bclk, .lrclk, .sd);
   stereo_dac_serial_audio_rx dut_u (.ref_clk, .resetn, .supply_reset_bar, .bit_clk(bclk),
      .frame_clk(lrclk), .serial_sample_in(sd), .framing_select_pin(pin),
      .framing_select_hiz(hiz), .mute_n, .left_out, .right_out, .sample_valid, .muted,
      .bit_clk_stopped, .ratio_locked, .ratio_index);
   initial forever #50 ref_clk = ~ref_clk;
   task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Wait for n output pairs, each bounded
   task automatic pairs(int n);
      repeat (n) begin
         tick(1);
         for (int t = 0; t < 1200 && sample_valid !== 1'b1; t++) tick(1);
         chk("pair", sample_valid, 24'h1);
      end
   endtask
   task automatic close_out;
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Model comparison at each pair once skip runs out, plus hang limit
   always begin
      @(posedge ref_clk);
      #2;
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         close_out;
      end
      if (sample_valid === 1'b1 && skip > 0) skip--;
      else if (sample_valid === 1'b1) begin
         chk("left", left_out, exp_l);
         chk("right", right_out, exp_r);
      end
   end
   initial begin
      tick(4);
      resetn = 1'b1;
      supply_reset_bar = 1'b1;
      tick(3);
      chk("stop", bit_clk_stopped, 24'h1);
      chk("mute", muted, 24'h1);
      // Every framing, surplus edges, short I2S slot
      for (int i = 0; i < 5; i++) begin
         fmt = cf[i];
         slot = cs[i];
         hiz = (fmt == FMT_RJ);
         pin = hiz ? 1'($random(seed)) : (fmt == FMT_I2S);
         lw = 24'($random(seed));
         rw = 24'($random(seed));
         exp_l = (slot == 6'h18 && fmt == FMT_I2S) ? {lw[23:1], 1'b0} : lw;
         exp_r = (slot == 6'h18 && fmt == FMT_I2S) ? {rw[23:1], 1'b0} : rw;
         skip = 3;
         run = 1'b1;
         pairs(6);
         chk("lock", ratio_locked, 24'h1);
         chk("ratio", ratio_index, ci[i]);
      end
      // Soft mute ramps, release is one step
      lw = 24'h400000;
      rw = 24'hC00000;
      exp_l = lw;
      exp_r = rw;
      skip = 3;
      pairs(5);
      mute_n = 1'b0;
      skip = 99;
      tick(5);
      chk("mute", muted, 24'h1);
      pairs(2);
      chk("ramp", left_out < lw, 24'h1);
      chk("ramp", $signed(right_out) > $signed(rw), 24'h1);
      mute_n = 1'b1;
      tick(5);
      chk("mute", muted, 24'h0);
      skip = 0;
      pairs(3);
      // Bit clock stops, then restarts
      run = 1'b0;
      tick(1000);
      chk("stop", bit_clk_stopped, 24'h1);
      chk("mute", muted, 24'h1);
      skip = 3;
      run = 1'b1;
      pairs(5);
      chk("mute", muted, 24'h0);
      // Supply reset mid-stream
      supply_reset_bar = 1'b0;
      skip = 99;
      mute_n = 1'($random(seed));
      tick(700);
      chk("left", left_out, 24'h0);
      chk("lock", ratio_locked, 24'h0);
      supply_reset_bar = 1'b1;
      mute_n = 1'b1;
      skip = 3;
      pairs(6);
      chk("lock", ratio_locked, 24'h1);
      close_out;
   end
endmodule
